// ==== hw/mrs_stack.sv ====
`timescale 1ns/1ns
`include "mrs_params.svh"

// ****************************************************************
// ****************************************************************

module mrs_stack
  import mrs_pkg::*;
#(
  parameter int DEPTH = `MRS_DEPTH,
  parameter logic [3:0] WCS_PAGE_BASE = `MRS_WCS_PAGE_BASE
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic uinst_valid,
  input wire mrs_uinst_type uinst,
  output mrs_branch_type branch,
  output logic [4:0] depth,
  output logic overflow,
  output logic underflow,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq
);

  // ****************************************************************
  // Register map and state
  // ****************************************************************
  localparam logic [3:0] REG_STATUS = `MRS_REG_STATUS;
  localparam logic [3:0] REG_MASK = `MRS_REG_MASK;
  localparam logic [3:0] REG_DEPTH = `MRS_REG_DEPTH;
  localparam logic [3:0] REG_TOP = `MRS_REG_TOP;

  typedef struct packed {
    logic [4:0] ptr;
    mrs_branch_type branch;
    logic overflow;
    logic underflow;
    logic [1:0] status;
    logic [1:0] mask;
    logic [15:0] rdata;
    logic irq;
  } mrs_state_type;

  mrs_state_type state;
  mrs_state_type next_state;
  logic [12:0] mem [0:DEPTH-1];
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [12:0] mem_wdata;
  logic [1:0] rst_sync;
  logic rst_n;
  mrs_op_type op;
  logic [12:0] ret_addr;
  logic [12:0] top_entry;
  logic ovf_event;
  logic unf_event;
  logic status_clear;
  logic mask_write;
  logic [1:0] event_flags;
  logic [1:0] status_next;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  mrs_decode u_decode (
    .uinst(uinst),
    .op(op),
    .ret_addr(ret_addr)
  );

  // Clamps a page into the writable store so a pop never collides with ROM pages
  function automatic logic [12:0] wcs_addr(input logic [12:0] a);
    logic [12:0] r;
    r = a;
    if (a[12:9] < WCS_PAGE_BASE) begin
      r[12:9] = WCS_PAGE_BASE;
    end
    return r;
  endfunction

  assign top_entry = (state.ptr == 5'h0) ? mem[0] : mem[4'(state.ptr - 5'h1)];

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Register port address match
  function automatic logic reg_sel(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  // Page branch target: page in the top bits, word zero
  function automatic logic [12:0] page_addr(input logic [3:0] pg);
    return {pg, 9'h0};
  endfunction

  // A push at this depth has nowhere to go
  function automatic logic stack_full(input logic [4:0] p);
    return p >= 5'(DEPTH);
  endfunction

  // Only the error entry is left, or nothing at all
  function automatic logic stack_low(input logic [4:0] p);
    return p <= 5'h1;
  endfunction

  // Readback mux; unmapped addresses read as zero
  function automatic logic [15:0] read_word(
    input logic [3:0] a,
    input logic [1:0] sts,
    input logic [1:0] mk,
    input logic [4:0] p,
    input logic [12:0] top
  );
    logic [15:0] w;
    case (a)
      REG_STATUS: w = {14'h0, sts};
      REG_MASK: w = {14'h0, mk};
      REG_DEPTH: w = {11'h0, p};
      REG_TOP: w = {3'h0, top};
      default: w = 16'h0;
    endcase
    return w;
  endfunction

  // ****************************************************************
  // Sticky event bits
  // ****************************************************************
  assign ovf_event = uinst_valid && (op == MRS_OP_PUSH) && stack_full(state.ptr);
  assign unf_event = uinst_valid && (op == MRS_OP_POP) && stack_low(state.ptr);
  assign event_flags = {unf_event, ovf_event};
  assign status_clear = reg_rd && reg_sel(reg_addr, REG_STATUS);
  assign mask_write = reg_wr && reg_sel(reg_addr, REG_MASK);

  // Bit 0 records overflow, bit 1 underflow; a status read clears both
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sticky
      // Set wins over a read-clear in the same cycle
      assign status_next[g] = event_flags[g] | (state.status[g] & ~status_clear);
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    mem_we = 1'b0;
    mem_waddr = 4'h0;
    mem_wdata = 13'h0;
    next_state.branch = '0;
    next_state.overflow = 1'b0;
    next_state.underflow = 1'b0;
    next_state.rdata = 16'h0;
    if (uinst_valid) begin
      case (op)
        MRS_OP_PUSH: begin
          next_state.branch.take = 1'b1;
          next_state.branch.addr = page_addr(uinst.page_select_field);
          if (stack_full(state.ptr)) begin
            next_state.branch.addr = mem[0];
            next_state.branch.from_stack = 1'b1;
            next_state.branch.error = 1'b1;
            next_state.overflow = 1'b1;
          end else begin
            mem_we = 1'b1;
            mem_waddr = 4'(state.ptr);
            mem_wdata = wcs_addr(ret_addr);
            next_state.ptr = state.ptr + 5'h1;
          end
        end
        MRS_OP_POP: begin
          next_state.branch.take = 1'b1;
          next_state.branch.from_stack = 1'b1;
          next_state.branch.addr = top_entry;
          if (stack_low(state.ptr)) begin
            next_state.branch.error = 1'b1;
            next_state.underflow = 1'b1;
          end else begin
            next_state.ptr = state.ptr - 5'h1;
          end
        end
        MRS_OP_DEL: begin
          next_state.branch.take = 1'b1;
          next_state.branch.addr = page_addr(uinst.page_select_field);
          if (state.ptr != 5'h0) begin
            next_state.ptr = state.ptr - 5'h1;
          end
        end
        default: begin
        end
      endcase
    end
    next_state.status = status_next;
    if (mask_write) begin
      next_state.mask = reg_wdata[1:0];
    end
    if (reg_rd) begin
      next_state.rdata = read_word(reg_addr, state.status, state.mask, state.ptr, top_entry);
    end
    next_state.irq = |(status_next & next_state.mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  assign branch = state.branch;
  assign depth = state.ptr;
  assign overflow = state.overflow;
  assign underflow = state.underflow;
  assign reg_rdata = state.rdata;
  assign irq = state.irq;

endmodule

// ==== hw/mrs_params.svh ====
`ifndef MRS_PARAMS_SVH
`define MRS_PARAMS_SVH

`define MRS_DEPTH 16
`define MRS_PTR_W 5
`define MRS_ADDR_W 13
`define MRS_PAGE_W 4
`define MRS_STACK_GROUP 4'he
`define MRS_STACK_BRANCH 2'h3
`define MRS_PUSH_BIT 1
`define MRS_POP_BIT 2
`define MRS_DEL_BIT 0
`define MRS_CYCLE_NS 190
`define MRS_CLK_NS 10
`define MRS_REG_STATUS 4'h0
`define MRS_REG_MASK 4'h1
`define MRS_REG_DEPTH 4'h2
`define MRS_REG_TOP 4'h3
`define MRS_WCS_PAGE_BASE 4'h1
`define MRS_CYCLE_CLKS ((`MRS_CYCLE_NS) / (`MRS_CLK_NS))

`endif

// ==== hw/mrs_pkg.sv ====
package mrs_pkg;

  // Fields of the current microinstruction that the stack looks at
  typedef struct packed {
    logic [1:0] sequence_function_field;
    logic [1:0] test_function_field;
    logic [3:0] micro_op_group_field;
    logic [1:0] low_branch_field;
    logic [3:0] a_operand_field;
    logic [3:0] b_operand_field;
    logic [2:0] word_mid_bits_field;
    logic [3:0] page_select_field;
    logic return_page_part_a;
    logic return_page_part_b;
    logic return_page_part_c;
    logic return_page_part_d;
  } mrs_uinst_type;

  typedef enum logic [3:0] {
    MRS_OP_NONE = 4'h1,
    MRS_OP_PUSH = 4'h2,
    MRS_OP_POP = 4'h4,
    MRS_OP_DEL = 4'h8
  } mrs_op_type;

  // Branch result handed back to the sequencer
  typedef struct packed {
    logic take;
    logic from_stack;
    logic error;
    logic [12:0] addr;
  } mrs_branch_type;

endpackage

// ==== hw/mrs_decode.sv ====
`timescale 1ns/1ns
`include "mrs_params.svh"

module mrs_decode
  import mrs_pkg::*;
(
  input wire mrs_uinst_type uinst,
  output mrs_op_type op,
  output logic [12:0] ret_addr
);

  logic common;

  always_comb begin
    common = (uinst.sequence_function_field == 2'h0) &&
             (uinst.test_function_field == 2'h0) &&
             (uinst.micro_op_group_field == `MRS_STACK_GROUP) &&
             (uinst.low_branch_field == `MRS_STACK_BRANCH);
    op = MRS_OP_NONE;
    if (common) begin
      if (uinst.a_operand_field[`MRS_PUSH_BIT]) begin
        op = MRS_OP_PUSH;
      end else if (uinst.a_operand_field[`MRS_POP_BIT] &&
                   !uinst.b_operand_field[`MRS_DEL_BIT]) begin
        op = MRS_OP_POP;
      end else if (uinst.a_operand_field[`MRS_POP_BIT]) begin
        op = MRS_OP_DEL;
      end
    end
    ret_addr = {uinst.return_page_part_d, uinst.return_page_part_a,
                uinst.return_page_part_b, uinst.return_page_part_c,
                2'h0, uinst.word_mid_bits_field, uinst.b_operand_field};
  end

endmodule

// ==== tb/mrs_stack_monitor.sv ====
`timescale 1ns/1ns
module mrs_stack_monitor
  import mrs_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic uinst_valid,
  input wire mrs_uinst_type uinst,
  input wire mrs_branch_type branch,
  input wire logic [4:0] depth,
  input wire logic overflow,
  input wire logic underflow
);
  localparam logic [4:0] FULL = 5'(DEPTH);
  logic sop, push, pop, del;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  assign sop = uinst_valid && clk_en && uinst.sequence_function_field == 2'h0
    && uinst.test_function_field == 2'h0 && uinst.micro_op_group_field == 4'he
    && uinst.low_branch_field == 2'h3 && (uinst.a_operand_field[1] || uinst.a_operand_field[2]);
  assign push = sop && uinst.a_operand_field[1];
  assign pop = sop && !uinst.a_operand_field[1] && !uinst.b_operand_field[0];
  assign del = sop && !uinst.a_operand_field[1] && uinst.b_operand_field[0];
  sequence s_pg;
    branch.take && branch.addr == {$past(uinst.page_select_field), 9'h0};
  endsequence
  property p_take; sop |=> branch.take; endproperty
  a_take: assert property (p_take) else $error("no branch after stack op");
  property p_idle; clk_en && !sop |=> !branch.take; endproperty
  a_idle: assert property (p_idle) else $error("branch without stack op");
  property p_push; push && depth < FULL |=> s_pg and !branch.from_stack; endproperty
  a_push: assert property (p_push) else $error("push page wrong");
  property p_del; del && depth != 5'h0 |=> s_pg and depth == $past(depth) - 5'h1; endproperty
  a_del: assert property (p_del) else $error("delete wrong");
  property p_pop; pop |=> branch.from_stack; endproperty
  a_pop: assert property (p_pop) else $error("pop not from stack");
  property p_grow; push && depth < FULL |=> depth == $past(depth) + 5'h1; endproperty
  a_grow: assert property (p_grow) else $error("push depth wrong");
  property p_ovf; push && depth == FULL |=> overflow && branch.error && $stable(depth); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_unf; pop && depth <= 5'h1 |=> underflow && branch.error && $stable(depth); endproperty
  a_unf: assert property (p_unf) else $error("underflow missed");
  property p_wcs; branch.take && branch.from_stack |-> branch.addr[12:9] != 4'h0; endproperty
  a_wcs: assert property (p_wcs) else $error("stored page outside store");
endmodule

// ==== tb/mrs_seq_model.sv ====
`timescale 1ns/1ns
module mrs_seq_model
  import mrs_pkg::*;
(
  input wire logic clk,
  output mrs_uinst_type uinst,
  output logic uinst_valid
);
  initial begin
    uinst = '0;
    uinst_valid = 1'b0;
  end
  task automatic issue(input logic [3:0] grp, input logic [3:0] a, input logic [3:0] pg,
      input logic [10:0] ret);
    @(posedge clk);
    uinst <= '{2'h0, 2'h0, grp, 2'h3, a[1] ? a & 4'hb : a, ret[3:0], ret[6:4], pg,
      ret[9], ret[8], ret[7], ret[10]};
    uinst_valid <= 1'b1;
    @(posedge clk);
    // Fields go stale once the word is gone
    uinst <= ~uinst;
    uinst_valid <= 1'b0;
    #1;
  endtask
endmodule

// ==== tb/tb_microprogram_return_stack.sv ====
`timescale 1ns/1ns
module tb_microprogram_return_stack;
  import mrs_pkg::*;
  logic clk, nrst, clk_en, reg_wr, reg_rd, irq, overflow, underflow, uinst_valid;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0] depth;
  mrs_uinst_type uinst;
  mrs_branch_type branch;
  int fails = 0;
  int tests_run = 0;
  mrs_seq_model seq (.clk, .uinst, .uinst_valid);
  mrs_stack dut (.clk, .nrst, .clk_en, .uinst_valid, .uinst, .branch, .depth, .overflow,
    .underflow, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [12:0] st(input logic [10:0] r);
    return {(r[10:7] == 4'h0) ? 4'h1 : r[10:7], 2'b00, r[6:0]};
  endfunction
  task automatic op(input logic [3:0] a, input logic [3:0] pg, input logic [10:0] ret,
      input logic [15:0] eb, input logic [4:0] ed);
    seq.issue(4'he, a, pg, ret);
    chk(branch, eb);
    chk({11'h0, depth}, {11'h0, ed});
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({11'h0, depth}, 16'h0);
    op(4'h2, 4'h2, 11'h5a5, {3'b100, 4'h2, 9'h0}, 5'h1);
    op(4'h2, 4'h3, 11'h07e, {3'b100, 4'h3, 9'h0}, 5'h2);
    op(4'h4, 4'h9, 11'h000, {3'b110, st(11'h07e)}, 5'h1);
    op(4'h4, 4'h9, 11'h000, {3'b111, st(11'h5a5)}, 5'h1);
    op(4'h6, 4'h3, 11'h0a0, {3'b100, 4'h3, 9'h0}, 5'h2);
    op(4'h4, 4'h6, 11'h001, {3'b100, 4'h6, 9'h0}, 5'h1);
    for (int i = 2; i <= 16; i++) begin
      op(4'h2, 4'h1, 11'h100, {3'b100, 4'h1, 9'h0}, 5'(i));
    end
    op(4'h2, 4'h1, 11'h100, {3'b111, st(11'h5a5)}, 5'h10);
    seq.issue(4'hd, 4'h2, 4'h1, 11'h0);
    chk({15'h0, branch.take}, 16'h0);
    $display("stack test done");
    rd(4'hf, 16'h0);
    @(posedge clk);
    reg_addr <= 4'h1;
    reg_wdata <= 16'h3;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h1);
    rd(4'h0, 16'h3);
    @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0);
    rd(4'h0, 16'h0);
    rd(4'h2, 16'h10);
    $display("register test done");
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk({11'h0, depth}, 16'h0);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // Entries survive reset, so popping the empty stack returns the error entry
    op(4'h4, 4'h9, 11'h000, {3'b111, st(11'h5a5)}, 5'h0);
    $display("reset test done");
    @(posedge clk);
    clk_en <= 1'b0;
    seq.issue(4'he, 4'h2, 4'h5, 11'h100);
    chk(branch, 16'h0);
    chk({11'h0, depth}, 16'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    $display("enable test done");
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
bind mrs_stack mrs_stack_monitor #(.DEPTH(DEPTH)) mon (.clk, .nrst, .clk_en, .uinst_valid,
  .uinst, .branch, .depth, .overflow, .underflow);
